// ---- bench/pci_config_extension_regs_test.sv ----
`timescale 1ns/1ps
module pci_config_extension_regs_test;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cfg_wr, cfg_rd, cfg_rvalid, snp_v, snp_io, snp_rd, vga_pass, sli_snoop, drive_en;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be, setup_wr;
  logic [31:0] cfg_wdata, cfg_rdata, snp_addr, rd_d;
  logic setup_acc = 0, setup_w = 0, fifo_req = 0, sli_act = 0, irq_req = 0, strap = 1;
  logic ring_osc = 0, rd_v, dac_sel, sum_sel, fifo_wr, inta_oe, nand_en, o_run, o_sel, o_frc;
  logic inta_out;
  logic [1:0] setup_idx = 2'h0;
  logic [31:0] status_w = 32'h5a5a_c3c3;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  pci_host_model i_host (.clk_i(clk_i), .cfg_rdata_i(cfg_rdata), .cfg_rvalid_i(cfg_rvalid),
    .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_addr_o(cfg_addr), .cfg_byte_en_o(cfg_be),
    .cfg_wdata_o(cfg_wdata), .snoop_valid_o(snp_v), .snoop_addr_o(snp_addr),
    .snoop_io_o(snp_io), .snoop_read_o(snp_rd));
  pci_config_extension_regs i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr),
    .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_byte_en_i(cfg_be), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid), .setup_access_i(setup_acc),
    .setup_write_i(setup_w), .setup_index_i(setup_idx), .setup_wr_o(setup_wr),
    .dac_readback_sel_o(dac_sel), .video_sum_sel_o(sum_sel), .fifo_wr_req_i(fifo_req),
    .fifo_wr_o(fifo_wr), .snoop_valid_i(snp_v), .snoop_addr_i(snp_addr), .snoop_io_i(snp_io),
    .snoop_read_i(snp_rd), .vga_pass_o(vga_pass), .sli_snoop_o(sli_snoop),
    .sli_active_i(sli_act), .pci_drive_en_o(drive_en), .irq_req_i(irq_req),
    .frame_addr_strap_bus_i(strap), .inta_out_o(inta_out), .inta_oe_o(inta_oe),
    .nand_tree_en_o(nand_en), .status_word_i(status_w), .ring_osc_i(ring_osc),
    .osc_run_o(o_run), .osc_sel_o(o_sel), .osc_force_o(o_frc));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_host.cfg_read(a, rd_d, rd_v);
    chk({31'h0, rd_v}, 32'h1);
    chk(rd_d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.cfg_write(a, d, 4'hf);
  endtask
  task automatic setup(input logic [1:0] idx, input logic w, input logic [5:0] exp);
    @(posedge clk_i) #1;
    {setup_acc, setup_w, setup_idx} = {1'b1, w, idx};
    @(posedge clk_i) #1;
    setup_acc = 1'b0;
    chk({setup_wr, dac_sel, sum_sel}, exp);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rd(8'h40, 32'h0019_5000);
    rd(8'h3c, 32'h0);
    rd(8'h50, 32'h0);
    rd(8'h58, 32'h0);
    i_host.cfg_write(8'h3c, 32'hffff_ffff, 4'hf);
    rd(8'h3c, 32'h0);
  endtask
  task automatic t_regs();
    wr(8'h50, 32'haaaa_5555);
    i_host.cfg_write(8'h50, 32'h1122_3344, 4'h4);
    rd(8'h50, 32'haa22_5555);
    wr(8'h50, 32'h1357_9bdf);
    rd(8'h50, 32'h1357_9bdf);
    wr(8'h44, 32'h1234_5678);
    wr(8'h48, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    rd(8'h48, 32'h0);
    rd(8'h4c, status_w);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'hfff9_5ff7);
    wr(8'h40, 32'h0040_0000);
    chk({31'h0, nand_en}, 32'h1);
  endtask
  task automatic t_gate();
    wr(8'h40, 32'h0);
    setup(2'h1, 1'b1, 6'h00);
    @(posedge clk_i) #1 fifo_req = 1'b1;
    @(posedge clk_i) #1 fifo_req = 1'b0;
    chk({31'h0, fifo_wr}, 32'h0);
    wr(8'h40, 32'h0000_0003);
    setup(2'h1, 1'b1, 6'h08);
    @(posedge clk_i) #1 fifo_req = 1'b1;
    @(posedge clk_i) #1 fifo_req = 1'b0;
    chk({31'h0, fifo_wr}, 32'h1);
    wr(8'h40, 32'h0000_0004);
    setup(2'h2, 1'b0, 6'h02);
    setup(2'h3, 1'b0, 6'h01);
  endtask
  task automatic t_snoop();
    wr(8'h44, 32'h0000_03f6);
    wr(8'h40, 32'h0000_0030);
    i_host.snoop(32'h0000_03f5, 1'b1, 1'b0);
    chk({31'h0, vga_pass}, 32'h0);
    i_host.snoop(32'h0000_03f6, 1'b1, 1'b1);
    i_host.snoop(32'h0000_03f6, 1'b0, 1'b0);
    chk({31'h0, vga_pass}, 32'h0);
    i_host.snoop(32'h0000_03f6, 1'b1, 1'b0);
    chk({31'h0, vga_pass}, 32'h1);
    chk({31'h0, cfg_rvalid}, 32'h0);
    wr(8'h40, 32'h0);
    @(posedge clk_i);
    #1 chk({31'h0, vga_pass}, 32'h0);
    wr(8'h48, 32'h1234_5673);
    wr(8'h40, 32'h0000_0280);
    i_host.snoop(32'h1234_5670, 1'b0, 1'b1);
    chk({31'h0, vga_pass}, 32'h1);
    wr(8'h40, 32'hab80_0000);
    i_host.snoop(32'hab00_1234, 1'b0, 1'b0);
    chk({31'h0, sli_snoop}, 32'h1);
    i_host.snoop(32'hac00_1234, 1'b0, 1'b0);
    chk({31'h0, sli_snoop}, 32'h0);
  endtask
  task automatic t_sli();
    sli_act = 1'b1;
    wr(8'h40, 32'h0000_0000);
    @(posedge clk_i);
    #1 chk({31'h0, drive_en}, 32'h1);
    wr(8'h40, 32'h0000_0400);
    @(posedge clk_i);
    #1 chk({31'h0, drive_en}, 32'h0);
    wr(8'h40, 32'h0000_0c00);
    @(posedge clk_i);
    #1 chk({31'h0, drive_en}, 32'h1);
  endtask
  task automatic t_irq();
    int low;
    wr(8'h40, 32'h0030_0000);
    @(posedge clk_i) #1 irq_req = 1'b1;
    @(posedge clk_i) #1 chk({31'h0, inta_oe}, 32'h1);
    chk({31'h0, inta_out}, 32'h0);
    irq_req = 1'b0;
    @(posedge clk_i) #1 irq_req = 1'b1;
    low = 0;
    repeat (32) @(posedge clk_i) #1 low += inta_oe ? 0 : 1;
    chk(low, 32);
    repeat (8) @(posedge clk_i);
    #1 chk({31'h0, inta_oe}, 32'h1);
    irq_req = 1'b0;
  endtask
  task automatic t_mon();
    wr(8'h54, 32'h7000_0000);
    chk({29'h0, o_frc, o_sel, o_run}, 32'h7);
    repeat (20) @(posedge clk_i) #1 ring_osc = ~ring_osc;
    repeat (3) @(posedge clk_i);
    i_host.cfg_read(8'h54, rd_d, rd_v);
    chk({31'h0, rd_v}, 32'h1);
    chk({16'h0, rd_d[15:0]}, 32'h000a);
    chk({20'h0, rd_d[27:16]}, 32'h0018);
    wr(8'h54, 32'h0);
    rd(8'h54, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    t_defaults();
    t_regs();
    t_gate();
    t_snoop();
    t_sli();
    t_irq();
    t_mon();
    print_verdict();
  end
endmodule // pci_config_extension_regs_test

// ---- bench/pci_host_model.sv ----
`timescale 1ns/1ps
module pci_host_model (
  input wire logic clk_i,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i,
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [7:0] cfg_addr_o,
  output logic [3:0] cfg_byte_en_o,
  output logic [31:0] cfg_wdata_o,
  output logic snoop_valid_o,
  output logic [31:0] snoop_addr_o,
  output logic snoop_io_o,
  output logic snoop_read_o
);
  initial begin
    {cfg_wr_o, cfg_rd_o, snoop_valid_o, snoop_io_o, snoop_read_o} = 5'h00;
    {cfg_addr_o, cfg_byte_en_o, cfg_wdata_o, snoop_addr_o} = '0;
  end
  ////////////////////////////////////////////////////////////////////
  // config write, strobe held across one taking edge
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_i) #1;
    {cfg_wr_o, cfg_addr_o, cfg_wdata_o, cfg_byte_en_o} = {1'b1, a, d, be};
    @(posedge clk_i) #1;
    cfg_wr_o = 1'b0;
    cfg_wdata_o = ~cfg_wdata_o;
  endtask
  // config read, answer sampled in the cycle after the taking edge
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk_i) #1;
    {cfg_rd_o, cfg_addr_o} = {1'b1, a};
    @(posedge clk_i) #1;
    cfg_rd_o = 1'b0;
    d = cfg_rdata_i;
    v = cfg_rvalid_i;
  endtask
  // observed address phase of another agent's cycle
  task automatic snoop(input logic [31:0] a, input logic io, input logic rd);
    @(posedge clk_i) #1;
    {snoop_valid_o, snoop_addr_o, snoop_io_o, snoop_read_o} = {1'b1, a, io, rd};
    @(posedge clk_i) #1;
    snoop_valid_o = 1'b0;
    snoop_addr_o = ~snoop_addr_o;
  endtask
endmodule // pci_host_model

// ---- inc/pci_cfg_ext_defines.svh ----
`ifndef PCI_CFG_EXT_DEFINES_SVH
`define PCI_CFG_EXT_DEFINES_SVH
// configuration space byte offsets
`define OFS_MAX_LATENCY 8'h3f
`define OFS_HDR_WORD 8'h3c
`define OFS_ACCESS_GATE 8'h40
`define OFS_SNOOP_ZERO 8'h44
`define OFS_SNOOP_ONE 8'h48
`define OFS_STATUS_ALIAS 8'h4c
`define OFS_SCRATCH 8'h50
`define OFS_PROC_MON 8'h54
// access gate field positions
`define GATE_SETUP_WR 0
`define GATE_FIFO_WR 1
`define GATE_REMAP 2
`define GATE_SNP0_EN 4
`define GATE_SNP0_IO 5
`define GATE_SNP0_RD 6
`define GATE_SNP1_EN 7
`define GATE_SNP1_IO 8
`define GATE_SNP1_RD 9
`define GATE_SLI_OWNER 10
`define GATE_SLI_ROLE 11
`define GATE_IRQ_EN 20
`define GATE_IRQ_GAP 21
`define GATE_NAND_TREE 22
`define GATE_SLI_SNP_EN 23
// writable bits of the access gate: 31:20, 11:4, 2:0
`define GATE_WR_MASK 32'hfff00ff7
// process monitor field positions
`define PM_RUN 28
`define PM_SEL 29
`define PM_FORCE 30
// reset values
`define MAX_LATENCY_RST 8'h00
`define GATE_RST 32'h00000000
`define SCRATCH_RST 32'h00000000
// interrupt pin least idle time between interrupts, in clocks
`define IRQ_GAP_CLKS 6'd32
`endif

// ---- inc/pci_cfg_ext_pkg.sv ----
package pci_cfg_ext_pkg;
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_ACTIVE = 2'b01,
    IRQ_GAP = 2'b11
  } irq_state_t;

  typedef struct packed {
    logic [31:0] gate;
    logic [31:0] snoop0;
    logic [31:0] snoop1;
    logic [31:0] scratch;
    logic [2:0] pm_ctl;
    logic [15:0] osc_cnt;
    logic [11:0] pci_cnt;
    logic osc_prev;
    logic [31:0] rdata;
    logic rvalid;
    logic [3:0] setup_wr;
    logic dac_sel;
    logic sum_sel;
    logic fifo_wr;
    logic vga_pass;
    logic sli_snoop;
    logic drive_en;
    irq_state_t irq_st;
    logic [5:0] gap_cnt;
    logic inta_oe;
    logic strap_done;
  } state_t;
endpackage

// ---- src/pci_config_extension_regs.sv ----
`timescale 1ns/1ps
`include "pci_cfg_ext_defines.svh"
// Summary of operation
// - max latency reads as constant zero
// - gate bit0 low drops setup register writes
// - gate bit1 enables pci fifo writes
// - gate bit2 remaps setup two/three
// - bits 6:4 configure snoop comparator zero
// - bits 9:7 configure snoop comparator one
// - bit11 picks interleave master or slave
// - drive bus when interleave inactive or bits 10,11 equal
// - revision and fab id are read only
// - bit20 interrupt enable, strap sampled at release
// - bit21 forces 32 clock interrupt gap
// - bit22 enables nand tree test mode
// - bit23 compares address 31:24 for snoop
// - snooping never claims observed transfer
// - low address bits compared for io only
// - snoop address registers read as zero
// - status alias returns memory status word
// - scratch word stores any value
// - monitor shows oscillator and pci counts
// - bit28 low holds oscillator counter reset
// - bit29 selects nand or nor oscillator
// - bit30 forces oscillator on
module pci_config_extension_regs #(
  parameter logic [3:0] SEC_REVISION = 4'h5, // arbitrary value
  parameter logic [3:0] FAB_ID = 4'h9 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_byte_en_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic setup_access_i,
  input wire logic setup_write_i,
  input wire logic [1:0] setup_index_i,
  output logic [3:0] setup_wr_o,
  output logic dac_readback_sel_o,
  output logic video_sum_sel_o,
  input wire logic fifo_wr_req_i,
  output logic fifo_wr_o,
  input wire logic snoop_valid_i,
  input wire logic [31:0] snoop_addr_i,
  input wire logic snoop_io_i,
  input wire logic snoop_read_i,
  output logic vga_pass_o,
  output logic sli_snoop_o,
  input wire logic sli_active_i,
  output logic pci_drive_en_o,
  input wire logic irq_req_i,
  input wire logic frame_addr_strap_bus_i,
  output logic inta_out_o,
  output logic inta_oe_o,
  output logic nand_tree_en_o,
  input wire logic [31:0] status_word_i,
  input wire logic ring_osc_i,
  output logic osc_run_o,
  output logic osc_sel_o,
  output logic osc_force_o
);
  import pci_cfg_ext_pkg::*;

  state_t st_reg;
  state_t st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic snoop_hit(input logic [31:0] ref_a, input logic en,
                                     input logic io_t, input logic rd_t,
                                     input logic [31:0] obs_a, input logic obs_io,
                                     input logic obs_rd);
    logic r;
    r = en && (obs_io == io_t) && (obs_rd == rd_t)
        && (obs_a[31:2] == ref_a[31:2])
        && (!io_t || (obs_a[1:0] == ref_a[1:0]));
    return r;
  endfunction

  logic [31:0] gate_rd;
  logic [31:0] pm_rd;
  logic hit0;
  logic hit1;
  logic sli_hit;
  logic osc_rise;

  assign gate_rd = {st_reg.gate[31:20], FAB_ID, SEC_REVISION,
                    st_reg.gate[11:4], 1'b0, st_reg.gate[2:0]};
  assign pm_rd = {1'b0, st_reg.pm_ctl, st_reg.pci_cnt, st_reg.osc_cnt};
  // observation only: nothing here drives or claims the bus cycle
  assign hit0 = snoop_hit(st_reg.snoop0, st_reg.gate[`GATE_SNP0_EN],
                          st_reg.gate[`GATE_SNP0_IO], st_reg.gate[`GATE_SNP0_RD],
                          snoop_addr_i, snoop_io_i, snoop_read_i);
  assign hit1 = snoop_hit(st_reg.snoop1, st_reg.gate[`GATE_SNP1_EN],
                          st_reg.gate[`GATE_SNP1_IO], st_reg.gate[`GATE_SNP1_RD],
                          snoop_addr_i, snoop_io_i, snoop_read_i);
  assign sli_hit = st_reg.gate[`GATE_SLI_SNP_EN]
                   && (snoop_addr_i[31:24] == st_reg.gate[31:24]);
  assign osc_rise = ring_osc_i && !st_reg.osc_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.setup_wr = 4'h0;
    st_next.dac_sel = 1'b0;
    st_next.sum_sel = 1'b0;
    st_next.fifo_wr = 1'b0;
    st_next.sli_snoop = 1'b0;

    // strap caught on first edge after reset release
    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.gate[`GATE_IRQ_EN] = frame_addr_strap_bus_i;
    end

    // configuration writes
    if (cfg_wr_i) begin
      case (cfg_addr_i & 8'hfc)
        `OFS_ACCESS_GATE: begin
          st_next.gate = merge_bytes(st_next.gate, cfg_wdata_i, cfg_byte_en_i)
                         & `GATE_WR_MASK;
        end
        `OFS_SNOOP_ZERO: begin
          st_next.snoop0 = merge_bytes(st_reg.snoop0, cfg_wdata_i, cfg_byte_en_i);
        end
        `OFS_SNOOP_ONE: begin
          st_next.snoop1 = merge_bytes(st_reg.snoop1, cfg_wdata_i, cfg_byte_en_i);
        end
        `OFS_SCRATCH: begin
          st_next.scratch = merge_bytes(st_reg.scratch, cfg_wdata_i, cfg_byte_en_i);
        end
        `OFS_PROC_MON: begin
          if (cfg_byte_en_i[3]) begin
            st_next.pm_ctl = cfg_wdata_i[`PM_FORCE:`PM_RUN];
          end
        end
        default: begin
        end
      endcase
    end

    // configuration reads, answered one clock later
    if (cfg_rd_i) begin
      st_next.rvalid = 1'b1;
      case (cfg_addr_i & 8'hfc)
        `OFS_HDR_WORD: st_next.rdata = {`MAX_LATENCY_RST, 24'h000000};
        `OFS_ACCESS_GATE: st_next.rdata = gate_rd;
        `OFS_SNOOP_ZERO: st_next.rdata = 32'h00000000;
        `OFS_SNOOP_ONE: st_next.rdata = 32'h00000000;
        `OFS_STATUS_ALIAS: st_next.rdata = status_word_i;
        `OFS_SCRATCH: st_next.rdata = st_reg.scratch;
        `OFS_PROC_MON: st_next.rdata = pm_rd;
        default: st_next.rdata = 32'h00000000;
      endcase
    end

    // hardware setup register access steering
    if (setup_access_i) begin
      if (st_reg.gate[`GATE_REMAP] && setup_index_i[1]) begin
        st_next.dac_sel = !setup_index_i[0];
        st_next.sum_sel = setup_index_i[0];
      end else if (setup_write_i && st_reg.gate[`GATE_SETUP_WR]) begin
        st_next.setup_wr = 4'h1 << setup_index_i;
      end
    end
    st_next.fifo_wr = fifo_wr_req_i && st_reg.gate[`GATE_FIFO_WR];

    // bus snooping
    if (snoop_valid_i && (hit0 || hit1)) begin
      st_next.vga_pass = 1'b1;
    end else if (!st_reg.gate[`GATE_SNP0_EN] && !st_reg.gate[`GATE_SNP1_EN]) begin
      st_next.vga_pass = 1'b0;
    end
    st_next.sli_snoop = snoop_valid_i && sli_hit;

    // interleave bus ownership
    st_next.drive_en = !sli_active_i
                       || (st_reg.gate[`GATE_SLI_OWNER] == st_reg.gate[`GATE_SLI_ROLE]);

    // interrupt pin
    case (st_reg.irq_st)
      IRQ_IDLE: begin
        if (irq_req_i && st_reg.gate[`GATE_IRQ_EN]) begin
          st_next.irq_st = IRQ_ACTIVE;
          st_next.inta_oe = 1'b1;
        end
      end
      IRQ_ACTIVE: begin
        if (!irq_req_i || !st_reg.gate[`GATE_IRQ_EN]) begin
          st_next.inta_oe = 1'b0;
          if (st_reg.gate[`GATE_IRQ_GAP]) begin
            st_next.irq_st = IRQ_GAP;
            st_next.gap_cnt = `IRQ_GAP_CLKS - 6'd1;
          end else begin
            st_next.irq_st = IRQ_IDLE;
          end
        end
      end
      IRQ_GAP: begin
        if (st_reg.gap_cnt == 6'd0) begin
          st_next.irq_st = IRQ_IDLE;
        end else begin
          st_next.gap_cnt = st_reg.gap_cnt - 6'd1;
        end
      end
      default: begin
        st_next.irq_st = IRQ_IDLE;
        st_next.inta_oe = 1'b0;
      end
    endcase

    // process monitor counters
    st_next.osc_prev = ring_osc_i;
    if (!st_reg.pm_ctl[0]) begin
      st_next.osc_cnt = 16'h0000;
      st_next.pci_cnt = 12'h000;
    end else begin
      st_next.pci_cnt = st_reg.pci_cnt + 12'h001;
      if (osc_rise) begin
        st_next.osc_cnt = st_reg.osc_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.gate <= `GATE_RST;
      st_reg.scratch <= `SCRATCH_RST;
      st_reg.irq_st <= IRQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign cfg_rdata_o = st_reg.rdata;
  assign cfg_rvalid_o = st_reg.rvalid;
  assign setup_wr_o = st_reg.setup_wr;
  assign dac_readback_sel_o = st_reg.dac_sel;
  assign video_sum_sel_o = st_reg.sum_sel;
  assign fifo_wr_o = st_reg.fifo_wr;
  assign vga_pass_o = st_reg.vga_pass;
  assign sli_snoop_o = st_reg.sli_snoop;
  assign pci_drive_en_o = st_reg.drive_en;
  assign inta_out_o = 1'b0;
  assign inta_oe_o = st_reg.inta_oe;
  assign nand_tree_en_o = st_reg.gate[`GATE_NAND_TREE];
  assign osc_run_o = st_reg.pm_ctl[0];
  assign osc_sel_o = st_reg.pm_ctl[1];
  assign osc_force_o = st_reg.pm_ctl[2];

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [6:0] idle_len;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_len <= 7'd0;
    end else if (inta_oe_o) begin
      idle_len <= 7'd0;
    end else if (idle_len != 7'd127) begin
      idle_len <= idle_len + 7'd1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_MAXLAT_ZERO: assert property (
    cfg_rd_i && ((cfg_addr_i & 8'hfc) == `OFS_HDR_WORD) |=> cfg_rdata_o[31:24] == 8'h00)
    else $error("max latency byte not zero");
  AST_SETUP_BLOCKED: assert property (
    setup_access_i && setup_write_i && !st_reg.gate[0] |=> setup_wr_o == 4'h0)
    else $error("setup write passed while gate closed");
  AST_FIFO_GATE: assert property (
    fifo_wr_req_i |=> fifo_wr_o == $past(st_reg.gate[1]))
    else $error("fifo write gating wrong");
  AST_REMAP: assert property (
    setup_access_i && st_reg.gate[2] && setup_index_i == 2'd3
    |=> video_sum_sel_o && !dac_readback_sel_o && setup_wr_o == 4'h0)
    else $error("remap of index three failed");
  AST_DRIVE: assert property (
    sli_active_i && (st_reg.gate[10] != st_reg.gate[11]) |=> !pci_drive_en_o)
    else $error("bus driven while not owner");
  AST_GATE_RO: assert property (
    cfg_rd_i && ((cfg_addr_i & 8'hfc) == `OFS_ACCESS_GATE)
    |=> cfg_rdata_o[19:12] == {FAB_ID, SEC_REVISION} && !cfg_rdata_o[3])
    else $error("read only gate fields wrong");
  AST_IRQ_GAP: assert property (
    $rose(inta_oe_o) && $past(st_reg.gate[21], 2) && idle_len != 7'd0
    |-> $past(idle_len) >= 7'd32)
    else $error("interrupt gap shorter than 32 clocks");
  AST_IRQ_OFF: assert property (
    !st_reg.gate[20] && st_reg.irq_st == IRQ_IDLE |=> !inta_oe_o)
    else $error("interrupt asserted while disabled");
  AST_SNOOP_RD: assert property (
    cfg_rd_i && ((cfg_addr_i & 8'hf8) == 8'h40) && cfg_addr_i[2] |=> cfg_rdata_o == 32'h0)
    else $error("snoop zero register readable");
  AST_VGA_SET: assert property (
    snoop_valid_i && (hit0 || hit1) |=> vga_pass_o)
    else $error("snoop match did not set pass pin");
  AST_SLI_SNOOP: assert property (
    snoop_valid_i && !st_reg.gate[23] |=> !sli_snoop_o)
    else $error("address snoop while disabled");
  AST_SCRATCH: assert property (
    cfg_wr_i && cfg_byte_en_i == 4'hf && ((cfg_addr_i & 8'hfc) == `OFS_SCRATCH)
    ##1 !cfg_wr_i
    ##1 cfg_rd_i && ((cfg_addr_i & 8'hfc) == `OFS_SCRATCH) && !cfg_wr_i
    |=> cfg_rdata_o == $past(cfg_wdata_i, 3))
    else $error("scratch readback mismatch");
  AST_PM_HOLD: assert property (
    !osc_run_o [*2] |-> st_reg.osc_cnt == 16'h0 && st_reg.pci_cnt == 12'h0)
    else $error("monitor counters run while held");
  AST_SNOOP1_RD: assert property (
    cfg_rd_i && ((cfg_addr_i & 8'hfc) == `OFS_SNOOP_ONE) |=> cfg_rdata_o == 32'h0)
    else $error("snoop one register readable");
  AST_STATUS_ALIAS: assert property (
    cfg_rd_i && ((cfg_addr_i & 8'hfc) == `OFS_STATUS_ALIAS) |=> cfg_rdata_o == $past(status_word_i))
    else $error("status alias differs from status word");
  AST_VGA_CLEAR: assert property (
    !st_reg.gate[4] && !st_reg.gate[7] |=> !vga_pass_o)
    else $error("pass pin held with snooping disabled");
  AST_SETUP_WR: assert property (
    setup_access_i && setup_write_i && st_reg.gate[0] && !(st_reg.gate[2] && setup_index_i[1])
    |=> setup_wr_o == (4'h1 << $past(setup_index_i)))
    else $error("setup write strobe missing or wrong");
  AST_REMAP_DAC: assert property (
    setup_access_i && st_reg.gate[2] && setup_index_i == 2'd2
    |=> dac_readback_sel_o && !video_sum_sel_o && setup_wr_o == 4'h0)
    else $error("remap of index two failed");
  AST_SLI_HIT: assert property (
    snoop_valid_i && st_reg.gate[23] && (snoop_addr_i[31:24] == st_reg.gate[31:24])
    |=> sli_snoop_o)
    else $error("address snoop match missed");
  AST_DRIVE_OWN: assert property (
    !sli_active_i || (st_reg.gate[10] == st_reg.gate[11]) |=> pci_drive_en_o)
    else $error("bus not driven while owner");
  AST_PM_CTL: assert property (
    cfg_wr_i && cfg_byte_en_i[3] && ((cfg_addr_i & 8'hfc) == `OFS_PROC_MON)
    |=> {osc_force_o, osc_sel_o, osc_run_o} == $past(cfg_wdata_i[30:28]))
    else $error("monitor control bits not taken");

  ////////////////////////////////////////////////////////////////////////////////
  // coverage

  COV_SNOOP: cover property (snoop_valid_i && hit1 ##1 vga_pass_o);
  COV_SLI_HIT: cover property (sli_snoop_o ##1 !sli_snoop_o);
  COV_GAP: cover property (st_reg.irq_st == IRQ_GAP ##[1:40] inta_oe_o);
  COV_REMAP: cover property (dac_readback_sel_o);
  COV_SETUP_WR: cover property (setup_wr_o == 4'h8);
endmodule // pci_config_extension_regs
